// ---- pkg/cmc_regs.vh ----
// Constants for the modem run-time configuration controller
`ifndef CMC_REGS_VH
`define CMC_REGS_VH
// Phase-step scale is 2^32
`define CMC_STEP_SHIFT 32
// Modulation index in 4.12 format
`define CMC_TX_MOD_INDEX 16'h0800
`define CMC_RX_MOD_INDEX_DEF 16'h8000
// Modulator control word fields
`define CMC_TXC_ORDER_LSB 0
`define CMC_TXC_SHAPE_LSB 4
`define CMC_TXC_TEST_LSB 8
`define CMC_TXC_SYNC_BIT 10
`define CMC_TXC_INV_BIT 11
`define CMC_ORDER_SOQPSK 3'h3
`define CMC_SHAPE_MIL 4'h5
`define CMC_SHAPE_TG 4'h6
`define CMC_TEST_NONE 2'h0
`define CMC_TEST_PRBS 2'h1
`define CMC_TEST_CARRIER 2'h3
// Receiver control word fields
`define CMC_RXC_INV_BIT 0
`define CMC_RXC_AFC_BIT 1
`define CMC_RXC_ACC_BIT 2
`define CMC_RXC_SYNC_BIT 3
`define CMC_RXC_FFT_BIT 4
`define CMC_RXC_STRIP_BIT 5
// Framing
`define CMC_SYNC_BITS 13'h0020
`define CMC_FRAME_LIMIT 13'h1fff
// Decimation and reset pulse
`define CMC_MIN_SPS 4
`define CMC_RESET_CYCLES 4'h4
`endif

// ---- hdl/cmc_fifo.v ----
// Small FIFO holding demodulated soft-decision words
`timescale 1ns/1ps
module cmc_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;
    // Honest flags from the occupancy count
    assign in_ready = (cnt_reg != DEPTH);
    assign out_valid = (cnt_reg != 0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Storage writes
    always @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    // Pointers and count
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

// ---- hdl/cmc_sync2.v ----
// Two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module cmc_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;
    // First stage is read only by the second
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ---- hdl/cmc_ctrl.v ----
// Controller that drives the modem's run-time configuration ports
//
// How it works
// - Modulator symbol step is rate over clock times 2^32.
// - Modulator index is 4.12, always held at 0x0800.
// - Modulator control bits 2:0 are three once loaded; reset leaves them zero.
// - Control bit 10 high once loaded to insert sync words; reset leaves it low.
// - Decimation ratio: one bypasses, zero forbidden, up to 16384.
// - Decimation should leave at least four samples per symbol.
// - Receiver symbol step is rate over clock times 2^32.
// - Receiver modulation order is always three.
// - Receiver index printed as 0x8000; kept as a parameter.
// - Receiver bit 3 sync detection set once loaded; reset leaves it clear.
// - Soft bit 3 is the decision, low bits grade confidence.
// - Pulse synchronous reset after start-up and every change.
`timescale 1ns/1ps
`include "cmc_regs.vh"
module cmc_ctrl #(
    parameter RX_MOD_INDEX = `CMC_RX_MOD_INDEX_DEF,
    parameter FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST,
    // User order: apply a new configuration
    input wire APPLY,
    output reg BUSY,
    output reg CFG_ERROR,
    // User modulator settings
    input wire [31:0] TX_SYMBOL_STEP,
    input wire [31:0] TX_CARRIER_STEP_IN,
    input wire [14:0] TX_GAIN_IN,
    input wire [12:0] TX_PAYLOAD_BITS,
    input wire [3:0] TX_SHAPE,
    input wire [1:0] TX_TEST,
    input wire TX_INVERT,
    // User receiver settings
    input wire [4:0] RX_TIME_CONST,
    input wire [31:0] RX_CARRIER_IN,
    input wire RX_UNDERSAMPLE,
    input wire [15:0] RX_DECIMATION,
    input wire [31:0] RX_SYMBOL_STEP,
    input wire [3:0] RX_SHAPE,
    input wire [12:0] RX_PAYLOAD_BITS,
    input wire RX_INVERT,
    input wire RX_AFC,
    input wire RX_FORCE_ACC,
    input wire RX_FFT,
    input wire RX_STRIP_SYNC,
    // Demodulated data from the device
    input wire [3:0] DEMOD_DATA,
    input wire DEMOD_STROBE,
    // Demodulated bits to the user
    output reg SOFT_VALID,
    input wire SOFT_READY,
    output reg [3:0] SOFT_DATA,
    output reg HARD_BIT,
    output reg [2:0] CONFIDENCE,
    output reg SOFT_OVERFLOW,
    // Device configuration ports
    output reg MODEM_SYNC_RESET,
    output reg [31:0] MOD_SYMBOL_RATE,
    output reg [15:0] MOD_INDEX,
    output reg [15:0] MOD_GAIN,
    output reg [31:0] TX_CARRIER_STEP,
    output reg [12:0] MOD_PAYLOAD_LEN,
    output reg [15:0] MOD_CONTROL,
    output reg [4:0] GAIN_LOOP_TIME_CONST,
    output reg [31:0] RX_CARRIER_NOMINAL,
    output reg [15:0] DECIMATION_RATIO,
    output reg [31:0] DEMOD_SYMBOL_RATE,
    output reg [1:0] DEMOD_ORDER,
    output reg [3:0] PULSE_SHAPE_SELECT,
    output reg [15:0] DEMOD_INDEX,
    output reg [12:0] DEMOD_FRAME_LEN,
    output reg [15:0] DEMOD_CONTROL
);
    // One-hot sequencer states
    localparam ST_IDLE = 3'b001;
    localparam ST_LOAD = 3'b010;
    localparam ST_RESET = 3'b100;
    // Minus one quarter of the clock as a phase step
    localparam [31:0] QUARTER_NEG = 32'hc0000000;
    localparam [16:0] MAX_DECIM = 17'h04000;

    reg [2:0] state_reg;
    reg [3:0] rst_cnt_reg;
    reg started_reg;
    wire [12:0] rx_total;
    wire tx_bad;
    wire rx_bad;
    wire decim_bad;
    wire sps_bad;
    wire [63:0] sps_product;
    wire [4:0] demod_sync;
    wire demod_strobe_sync;
    wire fifo_valid;
    wire fifo_in_ready;
    wire [3:0] fifo_data;
    wire fifo_pop;

    // Receiver frame length includes the 32-bit sync word
    assign rx_total = RX_PAYLOAD_BITS + `CMC_SYNC_BITS;
    // Payload checks: multiple of 8 and total under the limit, no wrap
    assign tx_bad = (TX_PAYLOAD_BITS[2:0] != 3'h0) || (TX_PAYLOAD_BITS > 13'h1fbf);
    assign rx_bad = (RX_PAYLOAD_BITS[2:0] != 3'h0) || (RX_PAYLOAD_BITS > 13'h1fbf);
    // Decimation legal range
    assign decim_bad = (RX_DECIMATION == 16'h0000) || ({1'b0, RX_DECIMATION} > MAX_DECIM);
    // Samples per symbol after decimation: R * step * 4 must not exceed 2^32
    assign sps_product = {32'h0, RX_SYMBOL_STEP} * {48'h0, RX_DECIMATION};
    assign sps_bad = (sps_product > 64'h0000000040000000);

    // Demodulator outputs cross in as pin inputs
    cmc_sync2 #(
        .WIDTH(5)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d({DEMOD_STROBE, DEMOD_DATA}),
        .q(demod_sync)
    );
    assign demod_strobe_sync = demod_sync[4];

    // Soft-decision buffer in the data path
    cmc_fifo #(
        .WIDTH(4),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .in_valid(demod_strobe_sync),
        .in_ready(fifo_in_ready),
        .in_data(demod_sync[3:0]),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );
    // Pop when the output stage is empty or being consumed
    assign fifo_pop = !SOFT_VALID || SOFT_READY;

    // Output stage splits decision and confidence
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SOFT_VALID <= 1'b0;
            SOFT_DATA <= 4'h0;
            HARD_BIT <= 1'b0;
            CONFIDENCE <= 3'h0;
            SOFT_OVERFLOW <= 1'b0;
        end else begin
            if (fifo_pop) begin
                SOFT_VALID <= fifo_valid;
                if (fifo_valid) begin
                    SOFT_DATA <= fifo_data;
                    HARD_BIT <= fifo_data[3];
                    CONFIDENCE <= fifo_data[2:0];
                end
            end
            // Sticky: a strobe into a full buffer is lost; cleared by APPLY
            if (demod_strobe_sync && !fifo_in_ready) begin
                SOFT_OVERFLOW <= 1'b1;
            end else if (APPLY && state_reg == ST_IDLE) begin
                SOFT_OVERFLOW <= 1'b0;
            end
        end
    end

    // Sequencer: validate, load ports, then pulse the modem reset
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            rst_cnt_reg <= 4'h0;
            started_reg <= 1'b0;
            BUSY <= 1'b0;
            CFG_ERROR <= 1'b0;
            MODEM_SYNC_RESET <= 1'b0;
            MOD_SYMBOL_RATE <= 32'h0;
            MOD_INDEX <= `CMC_TX_MOD_INDEX;
            MOD_GAIN <= 16'h0;
            TX_CARRIER_STEP <= 32'h0;
            MOD_PAYLOAD_LEN <= 13'h0;
            MOD_CONTROL <= 16'h0;
            GAIN_LOOP_TIME_CONST <= 5'h0;
            RX_CARRIER_NOMINAL <= 32'h0;
            DECIMATION_RATIO <= 16'h0001;
            DEMOD_SYMBOL_RATE <= 32'h0;
            DEMOD_ORDER <= 2'h3;
            PULSE_SHAPE_SELECT <= `CMC_SHAPE_MIL;
            DEMOD_INDEX <= RX_MOD_INDEX[15:0];
            DEMOD_FRAME_LEN <= 13'h0;
            DEMOD_CONTROL <= 16'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    MODEM_SYNC_RESET <= 1'b0;
                    if (!started_reg) begin
                        // First reset pulse after start-up
                        started_reg <= 1'b1;
                        BUSY <= 1'b1;
                        rst_cnt_reg <= `CMC_RESET_CYCLES;
                        state_reg <= ST_RESET;
                    end else if (APPLY) begin
                        BUSY <= 1'b1;
                        if (tx_bad || rx_bad || decim_bad || sps_bad) begin
                            CFG_ERROR <= 1'b1;
                            BUSY <= 1'b0;
                        end else begin
                            CFG_ERROR <= 1'b0;
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    MOD_SYMBOL_RATE <= TX_SYMBOL_STEP;
                    MOD_INDEX <= `CMC_TX_MOD_INDEX;
                    MOD_GAIN <= {1'b0, TX_GAIN_IN};
                    TX_CARRIER_STEP <= TX_CARRIER_STEP_IN;
                    MOD_PAYLOAD_LEN <= TX_PAYLOAD_BITS;
                    MOD_CONTROL <= {4'h0, TX_INVERT, 1'b1, TX_TEST,
                        TX_SHAPE, 1'b0, `CMC_ORDER_SOQPSK};
                    GAIN_LOOP_TIME_CONST <= RX_TIME_CONST;
                    RX_CARRIER_NOMINAL <= RX_UNDERSAMPLE ?
                        RX_CARRIER_IN + QUARTER_NEG : RX_CARRIER_IN;
                    DECIMATION_RATIO <= RX_DECIMATION;
                    DEMOD_SYMBOL_RATE <= RX_SYMBOL_STEP;
                    DEMOD_ORDER <= 2'h3;
                    PULSE_SHAPE_SELECT <= RX_SHAPE;
                    DEMOD_INDEX <= RX_MOD_INDEX[15:0];
                    DEMOD_FRAME_LEN <= rx_total;
                    DEMOD_CONTROL <= {10'h0, RX_STRIP_SYNC, RX_FFT, 1'b1,
                        RX_FORCE_ACC, RX_AFC, RX_INVERT};
                    rst_cnt_reg <= `CMC_RESET_CYCLES;
                    state_reg <= ST_RESET;
                end
                ST_RESET: begin
                    // Reset pulse follows every configuration change
                    MODEM_SYNC_RESET <= 1'b1;
                    if (rst_cnt_reg == 4'h1) begin
                        state_reg <= ST_IDLE;
                        BUSY <= 1'b0;
                    end
                    rst_cnt_reg <= rst_cnt_reg - 4'h1;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    BUSY <= 1'b0;
                    MODEM_SYNC_RESET <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ---- testbench/cmc_ctrl_sva.sv ----
// Port assertions for the modem configuration controller
`timescale 1ns/1ps
module cmc_ctrl_sva (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST,
    // Status
    input wire BUSY,
    input wire CFG_ERROR,
    // Soft data
    input wire SOFT_VALID,
    input wire SOFT_READY,
    input wire [3:0] SOFT_DATA,
    input wire HARD_BIT,
    input wire [2:0] CONFIDENCE,
    // Device side
    input wire MODEM_SYNC_RESET,
    input wire [15:0] MOD_INDEX,
    input wire [15:0] MOD_GAIN,
    input wire [12:0] MOD_PAYLOAD_LEN,
    input wire [15:0] MOD_CONTROL,
    input wire [1:0] DEMOD_ORDER,
    input wire [12:0] DEMOD_FRAME_LEN,
    input wire [15:0] DEMOD_CONTROL,
    // User setting behind the frame length
    input wire [12:0] RX_PAYLOAD_BITS
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Fixed device fields
    mod_index_a: assert property (MOD_INDEX == 16'h0800) else $error("index moved");
    demod_order_a: assert property (DEMOD_ORDER == 2'h3) else $error("order moved");
    gain_top_a: assert property (MOD_GAIN[15] == 1'b0) else $error("gain top set");
    // Control words carry the forced fields whenever they change
    tx_ctl_a: assert property ($changed(MOD_CONTROL) |->
        MOD_CONTROL[3:0] == 4'h3 && MOD_CONTROL[10]) else $error("tx control bad");
    rx_ctl_a: assert property ($changed(DEMOD_CONTROL) |->
        DEMOD_CONTROL[3] && DEMOD_CONTROL[15:6] == 10'h000) else $error("rx control bad");
    frame_len_a: assert property ($changed(DEMOD_FRAME_LEN) |->
        DEMOD_FRAME_LEN == $past(RX_PAYLOAD_BITS) + 13'h0020) else $error("frame length bad");
    // Soft word split and hold
    soft_split_a: assert property (SOFT_VALID |-> HARD_BIT == SOFT_DATA[3]
        && CONFIDENCE == SOFT_DATA[2:0]) else $error("soft split bad");
    soft_hold_a: assert property (SOFT_VALID && !SOFT_READY |=>
        SOFT_VALID && $stable(SOFT_DATA)) else $error("soft word dropped");
    // Modem reset pulse after start-up and each load
    reset_pulse_a: assert property ($rose(MODEM_SYNC_RESET) |->
        MODEM_SYNC_RESET [*4] ##1 !MODEM_SYNC_RESET) else $error("reset pulse length");
    load_pulse_a: assert property ($rose(BUSY) |->
        ##[1:2] $rose(MODEM_SYNC_RESET)) else $error("no reset pulse");
    reject_idle_a: assert property ($rose(CFG_ERROR) |->
        !BUSY [*2]) else $error("rejected load ran");
endmodule

// ---- testbench/cmc_modem_model.sv ----
// Behavioural model of the modem's configuration and soft-output ports
`timescale 1ns/1ps
module cmc_modem_model (
    // Clock
    input wire CORE_CLK,
    // Configuration
    input wire MODEM_SYNC_RESET,
    input wire [15:0] MOD_CONTROL,
    input wire [15:0] DEMOD_CONTROL,
    input wire [15:0] DECIMATION_RATIO,
    input wire [12:0] DEMOD_FRAME_LEN,
    // Soft-decision output
    output reg [3:0] DEMOD_DATA,
    output reg DEMOD_STROBE
);
    reg [15:0] tx_ctl_reg;
    reg [15:0] rx_ctl_reg;
    reg [15:0] decim_reg;
    reg [12:0] frame_reg;
    // Settings only take effect through the synchronous reset
    always @(posedge CORE_CLK) begin
        if (MODEM_SYNC_RESET) begin
            tx_ctl_reg <= MOD_CONTROL;
            rx_ctl_reg <= DEMOD_CONTROL;
            decim_reg <= DECIMATION_RATIO;
            frame_reg <= DEMOD_FRAME_LEN;
        end
    end
    initial begin
        DEMOD_DATA = 4'h0;
        DEMOD_STROBE = 1'b0;
    end
    // Back-to-back soft words, then data scrambled while idle
    task burst(input int n, input logic [3:0] first);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge CORE_CLK);
            #2;
            DEMOD_DATA = first + 4'(i);
            DEMOD_STROBE = 1'b1;
        end
        @(posedge CORE_CLK);
        #2;
        DEMOD_STROBE = 1'b0;
        DEMOD_DATA = ~DEMOD_DATA;
    endtask
endmodule

// ---- testbench/cmc_ctrl_tb_top.sv ----
// Self-checking bench for the modem configuration controller
`timescale 1ns/1ps
module cmc_ctrl_tb_top;
    reg CORE_CLK = 1'b0;
    reg RST = 1'b1;
    reg APPLY = 1'b0;
    reg [31:0] TX_SYMBOL_STEP, TX_CARRIER_STEP_IN, RX_CARRIER_IN, RX_SYMBOL_STEP;
    reg [14:0] TX_GAIN_IN;
    reg [12:0] TX_PAYLOAD_BITS, RX_PAYLOAD_BITS;
    reg [3:0] TX_SHAPE, RX_SHAPE;
    reg [1:0] TX_TEST;
    reg [4:0] RX_TIME_CONST;
    reg [15:0] RX_DECIMATION;
    reg TX_INVERT, RX_UNDERSAMPLE, RX_INVERT, RX_AFC, RX_FORCE_ACC, RX_FFT, RX_STRIP_SYNC;
    reg SOFT_READY;
    wire BUSY, CFG_ERROR, SOFT_VALID, HARD_BIT, SOFT_OVERFLOW, MODEM_SYNC_RESET, DEMOD_STROBE;
    wire [3:0] SOFT_DATA, PULSE_SHAPE_SELECT, DEMOD_DATA;
    wire [2:0] CONFIDENCE;
    wire [31:0] MOD_SYMBOL_RATE, TX_CARRIER_STEP, RX_CARRIER_NOMINAL, DEMOD_SYMBOL_RATE;
    wire [15:0] MOD_INDEX, MOD_GAIN, MOD_CONTROL, DECIMATION_RATIO, DEMOD_INDEX, DEMOD_CONTROL;
    wire [12:0] MOD_PAYLOAD_LEN, DEMOD_FRAME_LEN;
    wire [4:0] GAIN_LOOP_TIME_CONST;
    wire [1:0] DEMOD_ORDER;
    int bad_count = 0;
    int num_checks = 0;
    cmc_ctrl u_cmc_ctrl (.*);
    cmc_modem_model u_cmc_modem_model (.*);
    // 40 MHz clock
    always #12.5 CORE_CLK = ~CORE_CLK;
    task close_out;
        $display("Checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task step;
        @(posedge CORE_CLK);
        #2;
    endtask
    // Bounded wait for the controller to go idle
    task wait_idle;
        int n;
        n = 0;
        while (BUSY !== 1'b0 && n < 50) begin
            step;
            n++;
        end
        if (BUSY !== 1'b0) begin
            chk("BUSY", BUSY, 0);
            close_out;
        end
    endtask
    task apply;
        APPLY = 1'b1;
        step;
        APPLY = 1'b0;
        step;
        wait_idle;
        step;
    endtask
    // Valid load: every field mapped to the device
    task t_good(input logic [3:0] sh, input logic [1:0] tm, input logic inv);
        TX_SHAPE = sh;
        RX_SHAPE = sh;
        TX_TEST = tm;
        TX_INVERT = inv;
        RX_INVERT = inv;
        RX_AFC = ~inv;
        RX_FORCE_ACC = inv;
        RX_FFT = ~inv;
        RX_STRIP_SYNC = inv;
        RX_UNDERSAMPLE = inv;
        apply;
        chk("CFG_ERROR", CFG_ERROR, 0);
        chk("MODEM_SYNC_RESET", MODEM_SYNC_RESET, 0);
        chk("MOD_CONTROL", MOD_CONTROL, {20'h0, inv, 1'b1, tm, sh, 4'h3});
        chk("DEMOD_CONTROL", DEMOD_CONTROL, {26'h0, inv, ~inv, 1'b1, inv, ~inv, inv});
        chk("RX_CARRIER", RX_CARRIER_NOMINAL, RX_CARRIER_IN + (inv ? 32'hc0000000 : 0));
        chk("PULSE_SHAPE_SELECT", PULSE_SHAPE_SELECT, sh);
        chk("MOD_SYMBOL_RATE", MOD_SYMBOL_RATE, 32'h01000000);
        chk("TX_CARRIER_STEP", TX_CARRIER_STEP, 32'h23456789);
        chk("MOD_GAIN", MOD_GAIN, 16'h7fff);
        chk("MOD_PAYLOAD_LEN", MOD_PAYLOAD_LEN, 13'h0100);
        chk("DEMOD_FRAME_LEN", DEMOD_FRAME_LEN, 13'h0120);
        chk("DECIMATION_RATIO", DECIMATION_RATIO, 16'h0004);
        chk("DEMOD_SYMBOL_RATE", DEMOD_SYMBOL_RATE, 32'h01000000);
        chk("GAIN_LOOP", GAIN_LOOP_TIME_CONST, 5'h0b);
        chk("DEMOD_INDEX", DEMOD_INDEX, 16'h8000);
        chk("MOD_INDEX", MOD_INDEX, 16'h0800);
        chk("DEMOD_ORDER", DEMOD_ORDER, 2'h3);
        // The modem only sees the new words if the reset pulse followed the load
        chk("MODEM_TX_CONTROL", u_cmc_modem_model.tx_ctl_reg, {20'h0, inv, 1'b1, tm, sh, 4'h3});
        chk("MODEM_FRAME_LEN", u_cmc_modem_model.frame_reg, 13'h0120);
    endtask
    // Refused load leaves the device ports alone
    task t_bad(input logic [12:0] pl, input logic [15:0] dec);
        TX_PAYLOAD_BITS = pl;
        RX_PAYLOAD_BITS = pl;
        RX_DECIMATION = dec;
        APPLY = 1'b1;
        step;
        APPLY = 1'b0;
        step;
        step;
        chk("CFG_ERROR", CFG_ERROR, 1);
        chk("BUSY", BUSY, 0);
        chk("MOD_PAYLOAD_LEN", MOD_PAYLOAD_LEN, 13'h0100);
        chk("DECIMATION_RATIO", DECIMATION_RATIO, 16'h0004);
        TX_PAYLOAD_BITS = 13'h0100;
        RX_PAYLOAD_BITS = 13'h0100;
        RX_DECIMATION = 16'h0004;
    endtask
    // Fill the soft FIFO past full with the user stalled, then drain it
    task t_soft;
        int n;
        int k;
        n = 0;
        SOFT_READY = 1'b0;
        u_cmc_modem_model.burst(12, 4'h2);
        repeat (6) step;
        chk("SOFT_OVERFLOW", SOFT_OVERFLOW, 1);
        SOFT_READY = 1'b1;
        for (k = 0; k < 40; k++) begin
            if (SOFT_VALID === 1'b1) begin
                if (n < 9) begin
                    chk("SOFT_DATA", SOFT_DATA, 4'h2 + n);
                    chk("HARD_BIT", HARD_BIT, (4'h2 + n) >> 3);
                    chk("CONFIDENCE", CONFIDENCE, (4'h2 + n) & 7);
                end
                n++;
            end
            step;
        end
        // Eight words in the FIFO plus one in the output stage survive the stall
        chk("drained", n, 9);
        chk("SOFT_VALID", SOFT_VALID, 0);
        t_good(4'h5, 2'h0, 1'b0);
        chk("SOFT_OVERFLOW", SOFT_OVERFLOW, 0);
    endtask
    initial begin
        TX_SYMBOL_STEP = 32'h01000000;
        TX_CARRIER_STEP_IN = 32'h23456789;
        RX_CARRIER_IN = 32'h10000000;
        RX_SYMBOL_STEP = 32'h01000000;
        TX_GAIN_IN = 15'h7fff;
        TX_PAYLOAD_BITS = 13'h0100;
        RX_PAYLOAD_BITS = 13'h0100;
        {TX_SHAPE, RX_SHAPE, TX_TEST} = 10'h000;
        RX_TIME_CONST = 5'h0b;
        RX_DECIMATION = 16'h0004;
        {TX_INVERT, RX_UNDERSAMPLE, RX_INVERT, RX_AFC, RX_FORCE_ACC} = 5'h00;
        {RX_FFT, RX_STRIP_SYNC, SOFT_READY} = 3'h0;
        repeat (20) @(posedge CORE_CLK);
        #2;
        chk("DECIMATION_RATIO", DECIMATION_RATIO, 16'h0001);
        chk("PULSE_SHAPE_SELECT", PULSE_SHAPE_SELECT, 4'h5);
        chk("MODEM_SYNC_RESET", MODEM_SYNC_RESET, 0);
        RST = 1'b0;
        step;
        step;
        chk("MODEM_SYNC_RESET", MODEM_SYNC_RESET, 1);
        wait_idle;
        step;
        t_good(4'h5, 2'h0, 1'b0);
        t_good(4'h6, 2'h1, 1'b1);
        t_good(4'h5, 2'h3, 1'b1);
        t_bad(13'h0101, 16'h0004);
        t_bad(13'h1fc0, 16'h0004);
        t_bad(13'h0100, 16'h0000);
        t_bad(13'h0100, 16'h0100);
        t_good(4'h6, 2'h0, 1'b0);
        t_soft;
        close_out;
    end
endmodule
bind cmc_ctrl cmc_ctrl_sva u_cmc_ctrl_sva (.*);
